// ==== src/exc_ctrl_pkg.sv ====
// constants and carrier types for exception state and reset control
package exc_ctrl_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int           ADDR_W         = 12;
  localparam logic [11:0]  ICSR_OFFSET    = 12'hd04;
  localparam logic [11:0]  AIRCR_OFFSET   = 12'hd0c;

  // ---------------------------------------------------------------
  // interrupt_control_state fields
  // ---------------------------------------------------------------
  localparam int           TICK_SET_BIT   = 26;
  localparam int           TICK_CLR_BIT   = 25;
  localparam int           PREEMPT_BIT    = 23;
  localparam int           ANY_PEND_BIT   = 22;
  localparam int           VECT_PEND_LSB  = 12;
  localparam int           VECT_PEND_MSB  = 20;
  localparam int           ACTIVE_LSB     = 0;
  localparam int           ACTIVE_MSB     = 8;
  localparam logic [31:0]  ICSR_RESET     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // app_interrupt_reset_control fields
  // ---------------------------------------------------------------
  localparam int           KEY_LSB        = 16;
  localparam int           KEY_MSB        = 31;
  localparam int           RESET_REQ_BIT  = 2;
  localparam int           DBG_CLR_BIT    = 1;
  localparam logic [15:0]  KEY_WRITE      = 16'h05fa;
  localparam logic [15:0]  KEY_READ       = 16'hfa05;
  localparam logic [31:0]  AIRCR_RESET    = 32'hfa05_0000;

  // ---------------------------------------------------------------
  // exception numbering
  // ---------------------------------------------------------------
  localparam int           NUM_IRQ        = 32;
  localparam logic [8:0]   TICK_EXC_NUM   = 9'h00f;
  localparam logic [8:0]   IRQ_EXC_BASE   = 9'h010;
  localparam logic [8:0]   NO_EXC         = 9'h000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic                halt_preempt;
    logic                thread_mode;
    logic [8:0]          active_number;
    logic [NUM_IRQ-1:0]  irq_pending;
  } core_status_t;

endpackage : exc_ctrl_pkg

// ==== src/pending_selector.sv ====
// picks the highest-priority pending exception number
`timescale 1ns/1ps
module pending_selector
  import exc_ctrl_pkg::*;
(
  // pending sources
  input  wire logic               tick_pending,
  input  wire logic [NUM_IRQ-1:0] irq_pending,
  // result
  output logic [8:0]              number,
  output logic                    any_pending
);

  // lowest exception number wins; loop runs downward
  always_comb
  begin
    number = NO_EXC;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (irq_pending[i])
      begin
        number = IRQ_EXC_BASE + 9'(i);
      end
    end
    if (tick_pending)
    begin
      number = TICK_EXC_NUM;
    end
  end

  assign any_pending = tick_pending | (|irq_pending);

endmodule : pending_selector

// ==== src/reset_request_gen.sv ====
// holds the chip reset request until the reset it causes arrives
`timescale 1ns/1ps
module reset_request_gen
  import exc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // keyed write
  input  wire logic keyed_write,
  input  wire logic req_bit,
  input  wire logic dbg_bit,
  // outputs
  output logic      chip_reset_request,
  output logic      debug_active_clear
);

  logic req_reg;
  logic req_next;
  logic dbg_reg;

  // request stays until presetn clears it
  assign req_next = req_reg | (keyed_write & req_bit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_reg <= 1'b0;
      dbg_reg <= 1'b0;
    end
    else
    begin
      req_reg <= req_next;
      dbg_reg <= keyed_write & dbg_bit;
    end
  end

  assign chip_reset_request = req_reg;
  assign debug_active_clear = dbg_reg;

endmodule : reset_request_gen

// ==== src/exc_state_ctrl.sv ====
// exception state reporting and application reset control, apb slave
`timescale 1ns/1ps
module exc_state_ctrl
  import exc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire apb_req_t     apb_req,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // core side
  input  wire logic         tick_event,
  input  wire logic         tick_taken,
  input  wire core_status_t core_status,
  output logic              tick_pending_state,
  output logic [8:0]        highest_pending_number,
  // reset control
  output logic              chip_reset_request,
  output logic              debug_active_clear
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        setup_phase  = psel & ~penable;
  wire        access_phase = psel & penable;
  wire        hit_icsr     = (apb_req.paddr == ICSR_OFFSET);
  wire        hit_aircr    = (apb_req.paddr == AIRCR_OFFSET);
  wire        hit_any      = hit_icsr | hit_aircr;
  wire        wr_icsr      = access_phase & apb_req.pwrite & hit_icsr;
  wire        wr_aircr     = access_phase & apb_req.pwrite & hit_aircr;
  wire [15:0] wr_key       = apb_req.pwdata[KEY_MSB:KEY_LSB];
  wire        key_ok       = (wr_key == KEY_WRITE);
  wire        keyed_write  = wr_aircr & key_ok;
  wire        set_tick_wr  = wr_icsr & apb_req.pwdata[TICK_SET_BIT];
  wire        clr_tick_wr  = wr_icsr & apb_req.pwdata[TICK_CLR_BIT];

  // ---------------------------------------------------------------
  // tick pending state
  // ---------------------------------------------------------------
  logic tick_reg;
  logic tick_next;

  // set wins over any clear; handler entry clears
  assign tick_next = tick_event | set_tick_wr
                   | (tick_reg & ~clr_tick_wr & ~tick_taken);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
    end
  end

  assign tick_pending_state = tick_reg;

  // ---------------------------------------------------------------
  // pending selection
  // ---------------------------------------------------------------
  logic [8:0] pend_number;
  logic       pend_any;

  pending_selector u_sel (
    .tick_pending (tick_reg),
    .irq_pending  (core_status.irq_pending),
    .number       (pend_number),
    .any_pending  (pend_any)
  );

  assign highest_pending_number = pend_number;

  // ---------------------------------------------------------------
  // reset request
  // ---------------------------------------------------------------
  reset_request_gen u_rst (
    .pclk               (pclk),
    .presetn            (presetn),
    .keyed_write        (keyed_write),
    .req_bit            (apb_req.pwdata[RESET_REQ_BIT]),
    .dbg_bit            (apb_req.pwdata[DBG_CLR_BIT]),
    .chip_reset_request (chip_reset_request),
    .debug_active_clear (debug_active_clear)
  );

  // ---------------------------------------------------------------
  // read values
  // ---------------------------------------------------------------
  logic [31:0] icsr_rd;
  logic [31:0] aircr_rd;
  logic [8:0]  active_rd;

  assign active_rd = core_status.thread_mode ? NO_EXC
                   : core_status.active_number;

  // reserved positions stay zero
  always_comb
  begin
    icsr_rd                              = ICSR_RESET;
    icsr_rd[TICK_SET_BIT]                = tick_reg;
    icsr_rd[PREEMPT_BIT]                 = core_status.halt_preempt;
    icsr_rd[ANY_PEND_BIT]                = pend_any;
    icsr_rd[VECT_PEND_MSB:VECT_PEND_LSB] = pend_number;
    icsr_rd[ACTIVE_MSB:ACTIVE_LSB]       = active_rd;
  end

  // write-only bits read zero
  assign aircr_rd = AIRCR_RESET;

  wire [31:0] rd_mux = hit_icsr  ? icsr_rd
                     : hit_aircr ? aircr_rd
                     : 32'h0000_0000;

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  logic [31:0] prdata_reg;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (setup_phase & ~apb_req.pwrite)
    begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  wire rd_setup_icsr  = setup_phase & ~apb_req.pwrite & hit_icsr;
  wire rd_setup_aircr = setup_phase & ~apb_req.pwrite & hit_aircr;

  a_tick_set_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_tick_wr |=> tick_pending_state)
    else $error("tick pending not set by write");

  a_tick_zero_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_icsr & ~apb_req.pwdata[TICK_SET_BIT] & ~apb_req.pwdata[TICK_CLR_BIT]
     & ~tick_event & ~tick_taken) |=> $stable(tick_pending_state))
    else $error("zero write changed tick pending");

  a_tick_clear_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clr_tick_wr & ~apb_req.pwdata[TICK_SET_BIT] & ~tick_event)
    |=> !tick_pending_state)
    else $error("tick pending not cleared");

  a_tick_read_back: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_icsr |=> prdata[TICK_SET_BIT] == $past(tick_pending_state))
    else $error("tick pending read back wrong");

  a_preempt_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_icsr |=> prdata[PREEMPT_BIT] == $past(core_status.halt_preempt))
    else $error("preempt flag read wrong");

  a_any_pending_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_icsr |=> prdata[ANY_PEND_BIT] ==
      ($past(tick_pending_state) | (|$past(core_status.irq_pending))))
    else $error("any pending flag read wrong");

  a_vect_pending_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup_icsr & ~tick_reg & ~(|core_status.irq_pending))
    |=> prdata[VECT_PEND_MSB:VECT_PEND_LSB] == NO_EXC)
    else $error("pending number not zero when idle");

  a_vect_tick_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup_icsr & tick_reg)
    |=> prdata[VECT_PEND_MSB:VECT_PEND_LSB] == TICK_EXC_NUM)
    else $error("tick not reported as highest pending");

  a_active_thread: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup_icsr & core_status.thread_mode)
    |=> prdata[ACTIVE_MSB:ACTIVE_LSB] == NO_EXC)
    else $error("active field not zero in thread mode");

  a_key_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_aircr |=> prdata == AIRCR_RESET)
    else $error("reset control read wrong");

  a_bad_key_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_aircr & ~key_ok & ~chip_reset_request) |=> !chip_reset_request)
    else $error("unkeyed write raised reset request");

  a_reset_request: assert property (
    @(posedge pclk) disable iff (!presetn)
    (keyed_write & apb_req.pwdata[RESET_REQ_BIT]) |=> chip_reset_request [*3])
    else $error("reset request not raised and held");

  a_reset_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_request) |=> $stable(chip_reset_request))
    else $error("reset request dropped before reset");

  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_icsr |=> (prdata[31:27] == 5'h00) && !prdata[24] && !prdata[21]
                      && (prdata[11:9] == 3'h0))
    else $error("reserved bits not zero");

  a_tick_event_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick_event |=> tick_pending_state)
    else $error("tick event did not set pending");

  a_tick_taken_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick_taken & ~tick_event & ~set_tick_wr) |=> !tick_pending_state)
    else $error("handler entry did not clear tick pending");

  a_vect_irq_lowest: assert property (
    @(posedge pclk) disable iff (!presetn)
    (~tick_pending_state & core_status.irq_pending[0])
    |-> highest_pending_number == IRQ_EXC_BASE)
    else $error("lowest interrupt not reported first");

  a_vect_irq_pending: assert property (
    @(posedge pclk) disable iff (!presetn)
    (~tick_pending_state & (|core_status.irq_pending))
    |-> (highest_pending_number >= IRQ_EXC_BASE)
        && core_status.irq_pending[5'(highest_pending_number - IRQ_EXC_BASE)])
    else $error("reported interrupt is not pending");

  a_active_handler: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_setup_icsr & ~core_status.thread_mode)
    |=> prdata[ACTIVE_MSB:ACTIVE_LSB] == $past(core_status.active_number))
    else $error("active field not the handled exception");

  a_unmapped_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase & ~apb_req.pwrite & ~hit_any) |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_clear_bit_reads: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup_icsr |=> !prdata[TICK_CLR_BIT])
    else $error("write-only clear bit read back");

  a_dbg_needs_key: assert property (
    @(posedge pclk) disable iff (!presetn)
    debug_active_clear |-> $past(keyed_write))
    else $error("debug pulse without keyed write");

  a_req_needs_key: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_request) |-> $past(keyed_write & apb_req.pwdata[RESET_REQ_BIT]))
    else $error("reset request without keyed write");

  a_bad_key_no_dbg: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_aircr & ~key_ok) |=> !debug_active_clear)
    else $error("unkeyed write pulsed debug clear");

  a_icsr_no_request: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_icsr & ~chip_reset_request) |=> !chip_reset_request)
    else $error("status write raised reset request");

endmodule : exc_state_ctrl

// ==== tb/testbench.sv ====
// self-checking testbench for exception state and reset control
`timescale 1ns/1ps
`define CHK(a, b) \
  begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench
  import exc_ctrl_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  apb_req_t     apb_req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         tick_event;
  logic         tick_taken;
  core_status_t core_status;
  logic         tick_pending_state;
  logic [8:0]   highest_pending_number;
  logic         chip_reset_request;
  logic         debug_active_clear;
  int           fails;
  int           num_checks;
  int           cycles;
  int           m_tick;
  logic [31:0]  rnd;
  logic [31:0]  rd;
  logic         err;
  logic [15:0]  keys [4] = '{16'hfa05, 16'h05fb, 16'h0000, 16'h05fa};

  exc_state_ctrl dut_u (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .apb_req                (apb_req),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .tick_event             (tick_event),
    .tick_taken             (tick_taken),
    .core_status            (core_status),
    .tick_pending_state     (tick_pending_state),
    .highest_pending_number (highest_pending_number),
    .chip_reset_request     (chip_reset_request),
    .debug_active_clear     (debug_active_clear)
  );

  // ---------------------------------------------------------------
  // clock, timeout, helpers
  // ---------------------------------------------------------------
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // behavioural view of the status register
  function automatic logic [31:0] exp_icsr();
    logic [31:0] r;
    int          hp;
    hp = 0;
    if (m_tick != 0) hp = 15;
    else for (int i = NUM_IRQ - 1; i >= 0; i--) if (core_status.irq_pending[i]) hp = 16 + i;
    r = 32'h0000_0000;
    r[26] = (m_tick != 0);
    r[23] = core_status.halt_preempt;
    r[22] = (hp != 0);
    r[20:12] = hp[8:0];
    r[8:0] = core_status.thread_mode ? 9'h000 : core_status.active_number;
    return r;
  endfunction : exp_icsr

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    apb_req <= '{paddr: a, pwrite: wr, pwdata: d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    apb_req = '0;
    tick_event = 1'b0;
    tick_taken = 1'b0;
    core_status = '0;
    rnd = 32'd48;
    m_tick = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AIRCR_OFFSET, 32'h0);
    `CHK(rd, 32'hfa05_0000)
    apb(1'b0, ICSR_OFFSET, 32'h0);
    `CHK(rd, exp_icsr())
    // timer event sets, handler entry clears
    tick_event <= 1'b1;
    @(posedge pclk);
    tick_event <= 1'b0;
    @(posedge pclk);
    `CHK(tick_pending_state, 1'b1)
    `CHK(highest_pending_number, TICK_EXC_NUM)
    tick_taken <= 1'b1;
    @(posedge pclk);
    tick_taken <= 1'b0;
    @(posedge pclk);
    `CHK(tick_pending_state, 1'b0)
    // random status and set/clear writes
    for (int k = 0; k < 40; k++)
    begin
      rnd = lfsr(rnd);
      core_status.halt_preempt <= rnd[0];
      core_status.thread_mode <= rnd[1];
      core_status.active_number <= rnd[10:2];
      core_status.irq_pending <= rnd[3] ? 32'h0 : lfsr(rnd) & {rnd[15:0], rnd[31:16]};
      rnd = lfsr(rnd);
      apb(1'b1, ICSR_OFFSET, rnd);
      if (rnd[26]) m_tick = 1;
      else if (rnd[25]) m_tick = 0;
      @(posedge pclk);
      `CHK(tick_pending_state, m_tick[0])
      `CHK(highest_pending_number, exp_icsr() >> 12 & 32'h1ff)
      apb(1'b0, ICSR_OFFSET, 32'h0);
      `CHK(rd, exp_icsr())
      `CHK(err, 1'b0)
    end
    // explicit clear with set bit low
    apb(1'b1, ICSR_OFFSET, 32'h0400_0000);
    m_tick = 1;
    apb(1'b1, ICSR_OFFSET, 32'h0000_0000);
    @(posedge pclk);
    `CHK(tick_pending_state, m_tick[0])
    apb(1'b1, ICSR_OFFSET, 32'h0200_0000);
    m_tick = 0;
    @(posedge pclk);
    `CHK(tick_pending_state, m_tick[0])
    // unmapped address
    apb(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // keyed writes to the reset control register
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      apb(1'b1, AIRCR_OFFSET, {keys[k], rnd[15:0] & 16'hfff9});
      @(posedge pclk);
      `CHK(debug_active_clear, 1'b0)
      apb(1'b0, AIRCR_OFFSET, 32'h0);
      `CHK(rd, 32'hfa05_0000)
      apb(1'b1, AIRCR_OFFSET, {keys[k], 16'h0004});
      @(posedge pclk);
      `CHK(chip_reset_request, k == 3)
    end
    apb(1'b0, AIRCR_OFFSET, 32'h0);
    `CHK(rd, 32'hfa05_0000)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(chip_reset_request, 1'b0)
    presetn <= 1'b1;
    @(posedge pclk);
    results();
  end
endmodule : testbench
